// ### design/smb_cfg_mem.sv
`timescale 1ns/1ps
`default_nettype none
module smb_cfg_mem
   import smb_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       enable_in,
   input  wire logic       clear_in,
   input  wire logic       we_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] rdata_out
);
   logic [7:0] mem [CFG_WORDS];
   logic [7:0] next_mem [CFG_WORDS];
   logic [7:0] next_rdata;

   function automatic logic in_map(input logic [7:0] a);
      return (a >= IDX_CFG_FIRST) && (a <= IDX_CFG_LAST);
   endfunction

   function automatic logic [3:0] slot(input logic [7:0] a);
      logic [7:0] d;
      d = a - IDX_CFG_FIRST;
      return d[3:0];
   endfunction

   // indices outside the map swallow writes and read as zero
   always_comb begin
      for (int i = 0; i < CFG_WORDS; i++) begin
         next_mem[i] = clear_in ? CFG_RESET_VAL : mem[i];
      end
      if (!clear_in && we_in && in_map(addr_in)) begin
         next_mem[slot(addr_in)] = wdata_in;
      end
      next_rdata = in_map(addr_in) ? mem[slot(addr_in)] : CFG_RESET_VAL;
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < CFG_WORDS; i++) begin
            mem[i] <= CFG_RESET_VAL;
         end
         rdata_out <= CFG_RESET_VAL;
      end else if (enable_in) begin
         mem       <= next_mem;
         rdata_out <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ### design/smb_config_slave.sv
// What this block does
// - The block is only a bus target and accepts only write-byte and read-byte transfers.
// - Each access is a 7-bit target address, an 8-bit register index and an 8-bit data byte.
// - Every byte on the data line travels most significant bit first, in both directions.
// - A write is start, address, write bit, index, data, stop, with an acknowledge after each byte.
// - A read sets the index, then a repeated start with the read bit, one data byte, a nack and a stop.
// - Registers change only after a complete valid transfer; aborted transfers change nothing.
// - A wrong address or bad transfer gets no acknowledge and sends the logic back to idle.
// - Only the strapped target address is answered.
// - The all-zero general call address is never answered.
// - A clock-low period over 25 ms aborts the transfer and the block is ready within 35 ms.
// - Other agents may stretch the clock and the block never pulls the clock low.
// - A start directly followed by a stop resets the serial logic to idle.
// - There is no alert output and no alert response address.
// - In serial-load mode the block waits without limit and attaches to USB only afterwards.
// - The port shares pins with the eeprom port, and eeprom reads stay off in serial-load mode.
// - Setting status bit 0 signals USB attach and shuts the target down for good until reset.
`timescale 1ns/1ps
`default_nettype none
module smb_config_slave
   import smb_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)(
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       enable_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [6:0] target_addr_strap_in,
   input  wire logic       config_source_strap_hi_in,
   input  wire logic       config_source_strap_lo_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic            scl_out,
   output logic            scl_oe_out,
   output logic            eeprom_read_enable_out,
   output logic            usb_attach_out
);
   // ---- pin synchronisers ----
   logic [1:0] scl_sync, sda_sync, hi_sync, lo_sync;
   logic [6:0] addr_meta, addr_sync;
   logic       scl_prev, sda_prev;
   logic [1:0] next_scl_sync, next_sda_sync, next_hi_sync, next_lo_sync;
   logic [6:0] next_addr_meta, next_addr_sync;
   logic       next_scl_prev, next_sda_prev;

   // first stage feeds only the second; edges use the second and a copy
   always_comb begin
      next_scl_sync  = {scl_sync[0], scl_in};
      next_sda_sync  = {sda_sync[0], sda_in};
      next_hi_sync   = {hi_sync[0], config_source_strap_hi_in};
      next_lo_sync   = {lo_sync[0], config_source_strap_lo_in};
      next_addr_meta = target_addr_strap_in;
      next_addr_sync = addr_meta;
      next_scl_prev  = scl_sync[1];
      next_sda_prev  = sda_sync[1];
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         scl_sync  <= 2'h3;
         sda_sync  <= 2'h3;
         hi_sync   <= 2'h0;
         lo_sync   <= 2'h0;
         addr_meta <= 7'h00;
         addr_sync <= 7'h00;
         scl_prev  <= 1'h1;
         sda_prev  <= 1'h1;
      end else if (enable_in) begin
         scl_sync  <= next_scl_sync;
         sda_sync  <= next_sda_sync;
         hi_sync   <= next_hi_sync;
         lo_sync   <= next_lo_sync;
         addr_meta <= next_addr_meta;
         addr_sync <= next_addr_sync;
         scl_prev  <= next_scl_prev;
         sda_prev  <= next_sda_prev;
      end
   end

   logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
   assign scl_s     = scl_sync[1];
   assign sda_s     = sda_sync[1];
   assign scl_rise  = scl_s & ~scl_prev;
   assign scl_fall  = ~scl_s & scl_prev;
   assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
   assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

   // ---- link state ----
   smb_state_e  state, next_state;
   logic [3:0]  bit_cnt, next_bit_cnt;
   logic [7:0]  shift, next_shift;
   logic [7:0]  index, next_index;
   logic [7:0]  pend, next_pend;
   logic        restart, next_restart;
   logic        oe, next_oe;
   logic        attach, next_attach;
   logic        wprot, next_wprot;
   logic        strap_done, next_strap_done;
   logic [1:0]  strap_cnt, next_strap_cnt;
   logic        smbus_sel, next_smbus_sel;
   logic [6:0]  my_addr, next_my_addr;
   logic [31:0] to_cnt, next_to_cnt;
   logic        eep_en, next_eep_en;
   logic        attach_out, next_attach_out;
   logic        mem_we, mem_clear;
   logic [7:0]  mem_rdata, rd_byte;

   // registers change only through this one commit path at stop
   smb_cfg_mem u_mem (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .enable_in (enable_in),
      .clear_in  (mem_clear),
      .we_in     (mem_we),
      .addr_in   (index),
      .wdata_in  (pend),
      .rdata_out (mem_rdata)
   );

   function automatic logic addr_ok(input logic [7:0] b,
                                    input logic [6:0] mine,
                                    input logic       rd);
      return (b[7:1] == mine) && (b[7:1] != GENERAL_CALL) &&
             (b[0] == rd);
   endfunction

   assign rd_byte = (index == IDX_STATUS) ?
                    {5'h00, 1'h0, wprot, attach} : mem_rdata;

   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shift      = shift;
      next_index      = index;
      next_pend       = pend;
      next_restart    = restart;
      next_oe         = oe;
      next_attach     = attach;
      next_wprot      = wprot;
      next_strap_done = strap_done;
      next_strap_cnt  = strap_cnt;
      next_smbus_sel  = smbus_sel;
      next_my_addr    = my_addr;
      mem_we          = 1'h0;
      mem_clear       = 1'h0;
      // straps are caught once, after the synchronisers have filled
      if (!strap_done) begin
         next_strap_cnt = strap_cnt + 2'h1;
         if (strap_cnt == STRAP_SETTLE) begin
            next_strap_done = 1'h1;
            next_smbus_sel  = ({hi_sync[1], lo_sync[1]} == SRC_SEL_SMBUS);
            next_my_addr    = addr_sync;
         end
      end
      // timeout counts only while a transfer holds the clock low
      next_to_cnt = (!scl_s && state != ST_IDLE && state != ST_OFF) ?
                    to_cnt + 32'h1 : 32'h0;
      if (!strap_done || !smbus_sel || attach) begin
         next_state = attach ? ST_OFF : ST_IDLE;
         next_oe    = 1'h0;
      end else if (stop_det) begin
         if (state == ST_WAIT_STOP && !restart) begin
            if (index == IDX_STATUS) begin
               next_attach = attach | pend[BIT_ATTACH];
               next_wprot  = wprot | pend[BIT_WPROT];
               mem_clear   = pend[BIT_SOFT_RST];
            end else begin
               mem_we = ~wprot;
            end
         end
         next_state = ST_IDLE;
         next_oe    = 1'h0;
      end else if (start_det) begin
         // repeated start after the index ack: the start's own clock rise
         // has already shifted one bit into the data byte
         next_restart = (state == ST_DATA) && (bit_cnt == BIT_CNT_ONE);
         next_state   = ST_ADDR;
         next_bit_cnt = BIT_CNT_ZERO;
         next_oe      = 1'h0;
      end else if (to_cnt >= TIMEOUT_CYCLES - 1) begin
         next_state = ST_IDLE;
         next_oe    = 1'h0;
      end else begin
         case (state)
            ST_ADDR, ST_INDEX, ST_DATA: begin
               if (scl_rise) begin
                  next_shift   = {shift[6:0], sda_s};
                  next_bit_cnt = bit_cnt + BIT_CNT_ONE;
               end else if (scl_fall && bit_cnt == BIT_CNT_FULL) begin
                  next_bit_cnt = BIT_CNT_ZERO;
                  next_oe      = 1'h1;
                  if (state == ST_ADDR) begin
                     if (addr_ok(shift, my_addr, restart)) begin
                        next_state = ST_ADDR_ACK;
                     end else begin
                        next_state = ST_IDLE;
                        next_oe    = 1'h0;
                     end
                  end else if (state == ST_INDEX) begin
                     next_index = shift;
                     next_state = ST_INDEX_ACK;
                  end else begin
                     next_pend  = shift;
                     next_state = ST_DATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (restart) begin
                     next_state = ST_RD_DATA;
                     next_oe    = ~rd_byte[7];
                     next_shift = {rd_byte[6:0], 1'h0};
                  end else begin
                     next_state = ST_INDEX;
                     next_oe    = 1'h0;
                  end
               end
            end
            ST_INDEX_ACK: begin
               if (scl_fall) begin
                  next_state = ST_DATA;
                  next_oe    = 1'h0;
               end
            end
            ST_DATA_ACK: begin
               if (scl_fall) begin
                  next_state = ST_WAIT_STOP;
                  next_oe    = 1'h0;
               end
            end
            ST_WAIT_STOP: begin
               // the stop's own clock rise is legal; a full extra pulse is not
               if (scl_fall) begin
                  next_state = ST_IDLE;
               end
            end
            ST_RD_DATA: begin
               if (scl_fall) begin
                  if (bit_cnt == BIT_CNT_LAST) begin
                     next_oe    = 1'h0;
                     next_state = ST_RD_ACK;
                  end else begin
                     next_oe      = ~shift[7];
                     next_shift   = {shift[6:0], 1'h0};
                     next_bit_cnt = bit_cnt + BIT_CNT_ONE;
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  // host ack asks for a second byte, which is not allowed
                  next_state = sda_s ? ST_WAIT_STOP : ST_IDLE;
               end
            end
            default: begin
               next_state = state;
            end
         endcase
      end
      if (mem_clear) begin
         next_state = ST_IDLE;
      end
      next_eep_en     = strap_done & ~smbus_sel;
      next_attach_out = (strap_done & ~smbus_sel) | next_attach;
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state      <= ST_IDLE;
         bit_cnt    <= BIT_CNT_ZERO;
         shift      <= 8'h00;
         index      <= 8'h00;
         pend       <= 8'h00;
         restart    <= 1'h0;
         oe         <= 1'h0;
         attach     <= 1'h0;
         wprot      <= 1'h0;
         strap_done <= 1'h0;
         strap_cnt  <= 2'h0;
         smbus_sel  <= 1'h0;
         my_addr    <= 7'h00;
         to_cnt     <= 32'h0;
         eep_en     <= 1'h0;
         attach_out <= 1'h0;
      end else if (enable_in) begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         shift      <= next_shift;
         index      <= next_index;
         pend       <= next_pend;
         restart    <= next_restart;
         oe         <= next_oe;
         attach     <= next_attach;
         wprot      <= next_wprot;
         strap_done <= next_strap_done;
         strap_cnt  <= next_strap_cnt;
         smbus_sel  <= next_smbus_sel;
         my_addr    <= next_my_addr;
         to_cnt     <= next_to_cnt;
         eep_en     <= next_eep_en;
         attach_out <= next_attach_out;
      end
   end

   // open-drain: data only ever pulled low; clock never driven, no alert pin
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sda_out    <= 1'h0;
         sda_oe_out <= 1'h0;
         scl_out    <= 1'h0;
         scl_oe_out <= 1'h0;
         eeprom_read_enable_out <= 1'h0;
         usb_attach_out         <= 1'h0;
      end else if (enable_in) begin
         sda_out    <= 1'h0;
         sda_oe_out <= next_oe;
         scl_out    <= 1'h0;
         scl_oe_out <= 1'h0;
         eeprom_read_enable_out <= next_eep_en;
         usb_attach_out         <= next_attach_out;
      end
   end
endmodule
`default_nettype wire

// ### dv/smb_config_slave_properties.sv
`timescale 1ns/1ps
`default_nettype none
module smb_config_slave_properties
   import smb_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)(
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       enable_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [6:0] target_addr_strap_in,
   input  wire logic       config_source_strap_hi_in,
   input  wire logic       config_source_strap_lo_in,
   input  wire logic       sda_out,
   input  wire logic       sda_oe_out,
   input  wire logic       scl_out,
   input  wire logic       scl_oe_out,
   input  wire logic       eeprom_read_enable_out,
   input  wire logic       usb_attach_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   logic [31:0] low_cnt;
   logic [31:0] next_low_cnt;
   logic        serial_mode;

   // straps only move while reset is held, so this stays meaningful
   assign serial_mode = ({config_source_strap_hi_in,
                          config_source_strap_lo_in} == SRC_SEL_SMBUS);

   // length of the current clock-low stretch
   always_comb begin
      next_low_cnt = scl_in ? 32'h0 : low_cnt + 32'h1;
      if (!rst_n_in) begin
         next_low_cnt = 32'h0;
      end
   end
   always_ff @(posedge clock_in) begin
      low_cnt <= next_low_cnt;
   end

   // both bus lines high: a stop has just completed
   sequence bus_free;
      scl_in && sda_in;
   endsequence

   a_clock_never_driven: assert property (!scl_oe_out && !scl_out)
      else $error("bus clock driven by target");
   a_data_low_only: assert property (sda_oe_out |-> !sda_out)
      else $error("data pin driven high");
   a_oe_moves_low: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data pin changed while clock high");
   a_timeout_release: assert property
      (low_cnt > TIMEOUT_CYCLES + 8 |-> !sda_oe_out)
      else $error("data pin held after clock-low timeout");
   a_attach_sticky: assert property (usb_attach_out |=> usb_attach_out)
      else $error("attach dropped without reset");
   a_quiet_after_attach: assert property
      (usb_attach_out && serial_mode |-> !sda_oe_out)
      else $error("target answered after attach");
   a_attach_after_stop: assert property
      ($rose(usb_attach_out) && serial_mode |-> bus_free)
      else $error("attach raised while bus busy");
   a_eeprom_off_serial: assert property
      (serial_mode |-> !eeprom_read_enable_out)
      else $error("eeprom read enabled in serial mode");
   a_eeprom_attach: assert property
      ($rose(eeprom_read_enable_out) |-> ##[0:2] usb_attach_out)
      else $error("eeprom mode without attach");
   a_reset_quiet: assert property ($rose(rst_n_in) |->
      !usb_attach_out && !sda_oe_out && !eeprom_read_enable_out)
      else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ### dv/smb_config_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smb_config_slave_tb
   import smb_pkg::*;
;
   localparam logic [6:0] TGT    = 7'h2C; // strapped address, arbitrary
   localparam int unsigned TO_CYC = 200;  // shortened clock-low limit

   logic       clock_in  = 1'b0;
   logic       rst_n_in  = 1'b0;
   logic [1:0] src_strap = SRC_SEL_SMBUS;
   logic       scl_host;
   logic       sda_low;
   logic       sda_out;
   logic       sda_oe_out;
   logic       scl_out;
   logic       scl_oe_out;
   logic       eeprom_read_enable_out;
   logic       usb_attach_out;
   wire logic  scl_wire;
   wire logic  sda_wire;
   int         err_total   = 0;
   int         comparisons = 0;

   // open-drain lines with pull-ups: any low driver wins
   assign scl_wire = !(scl_oe_out && !scl_out) && scl_host;
   assign sda_wire = !(sda_oe_out && !sda_out) && !sda_low;

   always #2 clock_in = ~clock_in;

   smb_config_slave #(.TIMEOUT_CYCLES(TO_CYC)) smb_config_slave_i (
      .clock_in, .rst_n_in, .enable_in(1'b1), .scl_in(scl_wire),
      .sda_in(sda_wire), .target_addr_strap_in(TGT),
      .config_source_strap_hi_in(src_strap[1]),
      .config_source_strap_lo_in(src_strap[0]),
      .sda_out, .sda_oe_out, .scl_out, .scl_oe_out,
      .eeprom_read_enable_out, .usb_attach_out);

   smb_host_model smb_host_model_i (
      .sda_line_in(sda_wire), .scl_line_out(scl_host),
      .sda_low_out(sda_low));

   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // straps only change while reset is held
   task automatic do_reset(input logic [1:0] strap);
      @(posedge clock_in);
      #1 rst_n_in = 1'b0;
      src_strap = strap;
      repeat (4) @(posedge clock_in);
      #1 rst_n_in = 1'b1;
      repeat (20) @(posedge clock_in);
      // keeps every later pin change and check off the sampling edge
      #1;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] idx,
                     input logic [7:0] dat, output logic [2:0] ak);
      logic [7:0] rx;
      smb_host_model_i.start_cond();
      smb_host_model_i.xfer({a, RW_WRITE}, rx, ak[2]);
      smb_host_model_i.xfer(idx, rx, ak[1]);
      smb_host_model_i.xfer(dat, rx, ak[0]);
      smb_host_model_i.stop_cond();
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] idx,
                     output logic [7:0] dat, output logic [2:0] ak);
      logic nk;
      smb_host_model_i.start_cond();
      smb_host_model_i.xfer({a, RW_WRITE}, dat, ak[2]);
      smb_host_model_i.xfer(idx, dat, ak[1]);
      smb_host_model_i.start_cond();
      smb_host_model_i.xfer({a, RW_READ}, dat, ak[0]);
      smb_host_model_i.xfer(8'hFF, dat, nk);
      smb_host_model_i.stop_cond();
   endtask

   task automatic t_reset_state();
      chk({7'h0, eeprom_read_enable_out}, 8'h00);
      chk({7'h0, usb_attach_out}, 8'h00);
      chk({7'h0, sda_oe_out}, 8'h00);
   endtask

   // asymmetric values catch a reversed bit order; both map ends
   task automatic t_write_read();
      logic [7:0] idx [3] = '{8'h01, 8'h05, 8'h10};
      logic [7:0] val [3] = '{8'hC1, 8'h3E, 8'h80};
      logic [7:0] d;
      logic [2:0] ak;
      for (int i = 0; i < 3; i++) begin
         wr(TGT, idx[i], val[i], ak);
         chk({5'h0, ak}, 8'h07);
         rd(TGT, idx[i], d, ak);
         chk({5'h0, ak}, 8'h07);
         chk(d, val[i]);
      end
   endtask

   task automatic t_foreign_addr();
      logic [6:0] bad [2] = '{TGT ^ 7'h01, GENERAL_CALL};
      logic [7:0] d;
      logic [2:0] ak;
      for (int i = 0; i < 2; i++) begin
         wr(bad[i], 8'h07, 8'hFF, ak);
         chk({5'h0, ak}, 8'h00);
      end
      rd(TGT, 8'h07, d, ak);
      chk(d, 8'h00);
   endtask

   // mode 0: extra byte, 1: clock held low before data, 2: start then stop
   task automatic t_aborted_write(input int mode, input logic [7:0] idx);
      logic [7:0] d;
      logic [2:0] ak;
      logic       a;
      smb_host_model_i.start_cond();
      smb_host_model_i.xfer({TGT, RW_WRITE}, d, a);
      smb_host_model_i.xfer(idx, d, a);
      if (mode == 1) begin
         // the target must drop back to idle while the clock is low
         #(TO_CYC * 12);
      end
      smb_host_model_i.xfer(8'h77, d, a);
      if (mode == 1) begin
         chk({7'h0, a}, 8'h00);
      end else if (mode == 0) begin
         smb_host_model_i.xfer(8'h66, d, a);
         chk({7'h0, a}, 8'h00);
      end else begin
         smb_host_model_i.start_cond();
      end
      smb_host_model_i.stop_cond();
      rd(TGT, idx, d, ak);
      chk({5'h0, ak}, 8'h07);
      chk(d, 8'h00);
   endtask

   task automatic t_unmapped();
      logic [7:0] d;
      logic [2:0] ak;
      wr(TGT, 8'h40, 8'h5A, ak);
      chk({5'h0, ak}, 8'h07);
      rd(TGT, 8'h40, d, ak);
      chk(d, 8'h00);
   endtask

   // soft clear empties the map; write protect then blocks map writes
   task automatic t_status_bits();
      logic [7:0] d;
      logic [2:0] ak;
      wr(TGT, 8'h05, 8'h5A, ak);
      wr(TGT, IDX_STATUS, 8'h04, ak);
      rd(TGT, 8'h05, d, ak);
      chk(d, 8'h00);
      wr(TGT, IDX_STATUS, 8'h02, ak);
      rd(TGT, IDX_STATUS, d, ak);
      chk(d, 8'h02);
      wr(TGT, 8'h05, 8'h33, ak);
      chk({5'h0, ak}, 8'h07);
      rd(TGT, 8'h05, d, ak);
      chk(d, 8'h00);
   endtask

   task automatic t_attach();
      logic [2:0] ak;
      wr(TGT, IDX_STATUS, 8'h01, ak);
      repeat (4) @(posedge clock_in);
      #1;
      chk({7'h0, usb_attach_out}, 8'h01);
      wr(TGT, 8'h05, 8'h11, ak);
      chk({5'h0, ak}, 8'h00);
   endtask

   task automatic t_eeprom_mode();
      logic [2:0] ak;
      do_reset(2'h2);
      chk({7'h0, eeprom_read_enable_out}, 8'h01);
      chk({7'h0, usb_attach_out}, 8'h01);
      wr(TGT, 8'h05, 8'h11, ak);
      chk({5'h0, ak}, 8'h00);
   endtask

   // cuts a hang well past the expected run of about 76 us
   initial begin
      #150000;
      err_total++;
      wrap_up();
   end

   initial begin
      do_reset(SRC_SEL_SMBUS);
      t_reset_state();
      t_write_read();
      t_foreign_addr();
      t_aborted_write(0, 8'h08);
      t_aborted_write(1, 8'h09);
      t_aborted_write(2, 8'h0A);
      t_unmapped();
      t_status_bits();
      t_attach();
      t_eeprom_mode();
      wrap_up();
   end
endmodule

bind smb_config_slave smb_config_slave_properties
   #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) smb_config_slave_properties_i (
   .clock_in, .rst_n_in, .enable_in, .scl_in, .sda_in,
   .target_addr_strap_in, .config_source_strap_hi_in,
   .config_source_strap_lo_in, .sda_out, .sda_oe_out, .scl_out,
   .scl_oe_out, .eeprom_read_enable_out, .usb_attach_out);
`default_nettype wire

// ### dv/smb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smb_host_model (
   input  wire logic sda_line_in,
   output logic      scl_line_out,
   output logic      sda_low_out
);
   // quarter of the 80 ns bus clock period
   localparam time Q = 20;

   // idle bus: both lines released to their pull-ups
   initial begin
      scl_line_out = 1'b1;
      sda_low_out  = 1'b0;
   end

   // one bit slot: data set mid-low, sampled mid-high
   task automatic bit_slot(input logic tx, output logic rx);
      #Q sda_low_out = ~tx;
      #Q scl_line_out = 1'b1;
      #Q rx = sda_line_in;
      #Q scl_line_out = 1'b0;
   endtask

   // byte msb first, ninth slot released: ack seen, or nack sent on a read
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                       output logic acked);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(tx[i], b);
         rx[i] = b;
      end
      bit_slot(1'b1, b);
      acked = ~b;
   endtask

   // works from idle and as a repeated start with the clock low
   task automatic start_cond();
      #Q sda_low_out = 1'b0;
      #Q scl_line_out = 1'b1;
      #Q sda_low_out = 1'b1;
      #Q scl_line_out = 1'b0;
   endtask

   task automatic stop_cond();
      #Q sda_low_out = 1'b1;
      #Q scl_line_out = 1'b1;
      #Q sda_low_out = 1'b0;
      #(4*Q);
   endtask
endmodule
`default_nettype wire

// ### include/smb_pkg.sv
package smb_pkg;
   // bus framing
   localparam int unsigned ADDR_BITS      = 7;
   localparam int unsigned BYTE_BITS      = 8;
   localparam logic [3:0]  BIT_CNT_FULL   = 4'h8;
   localparam logic [3:0]  BIT_CNT_LAST   = 4'h7;
   localparam logic [3:0]  BIT_CNT_ZERO   = 4'h0;
   localparam logic [3:0]  BIT_CNT_ONE    = 4'h1;
   localparam logic [6:0]  GENERAL_CALL   = 7'h00;
   localparam logic        RW_WRITE       = 1'h0;
   localparam logic        RW_READ        = 1'h1;

   // register map
   localparam logic [7:0]  IDX_STATUS     = 8'h00;
   localparam logic [7:0]  IDX_CFG_FIRST  = 8'h01;
   localparam logic [7:0]  IDX_CFG_LAST   = 8'h10;
   localparam int unsigned CFG_WORDS      = 16;
   localparam logic [7:0]  CFG_RESET_VAL  = 8'h00;
   localparam int unsigned BIT_ATTACH     = 0;
   localparam int unsigned BIT_WPROT      = 1;
   localparam int unsigned BIT_SOFT_RST   = 2;

   // strap coding that selects the serial target load (arbitrary choice)
   localparam logic [1:0]  SRC_SEL_SMBUS  = 2'h1;
   localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

   // clock-low timeout
   localparam int unsigned CLK_PERIOD_PS  = 4000;
   localparam int unsigned TIMEOUT_MS     = 25;
   localparam int unsigned PS_PER_MS      = 1000000000;
   localparam longint unsigned TIMEOUT_PS =
      longint'(TIMEOUT_MS) * longint'(PS_PER_MS);
   localparam int unsigned TIMEOUT_CYC    =
      int'((TIMEOUT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // one-hot link states
   typedef enum logic [10:0] {
      ST_IDLE      = 11'h001,
      ST_ADDR      = 11'h002,
      ST_ADDR_ACK  = 11'h004,
      ST_INDEX     = 11'h008,
      ST_INDEX_ACK = 11'h010,
      ST_DATA      = 11'h020,
      ST_DATA_ACK  = 11'h040,
      ST_WAIT_STOP = 11'h080,
      ST_RD_DATA   = 11'h100,
      ST_RD_ACK    = 11'h200,
      ST_OFF       = 11'h400
   } smb_state_e;
endpackage
